// file: hw/sadc_clkdiv.sv
// Converter clock enable divider
`timescale 1ns/100ps
`default_nettype none
`include "sadc_consts.svh"
module sadc_clkdiv (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       run_i,
    input  wire logic [1:0] speed_i,
    output logic            tick_o
);
    import sadc_pkg::*;
    logic [3:0] cnt_q;
    logic [3:0] div;

    function automatic logic [3:0] div_of(input logic [1:0] s);
        case (s)
            2'b00:   div_of = 4'(`SADC_DIV_SPD0);
            2'b01:   div_of = 4'(`SADC_DIV_SPD1);
            2'b10:   div_of = 4'(`SADC_DIV_SPD2);
            default: div_of = 4'(`SADC_DIV_SPD3);
        endcase
    endfunction

    assign div    = div_of(speed_i);
    // Code 01 gives one tick per four clocks
    assign tick_o = run_i && (cnt_q == div - 4'h1);

    always_ff @(posedge clk_i) begin
        if (!nrst_i || !run_i || tick_o) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick_o && speed_i == 2'b01 && run_i) ##1 (run_i && speed_i == 2'b01)[*4]
        |-> tick_o && !$past(tick_o, 1) && !$past(tick_o, 2) && !$past(tick_o, 3))
        else $error("converter tick spacing wrong for speed 01");
endmodule : sadc_clkdiv
`default_nettype wire

// file: hw/sadc_consts.svh
// Constants for the successive-approximation converter sequencer
// Overview of operation
// - Control bits seven to five choose one of eight analog channels.
// - Setting control bit zero begins a conversion.
// - Approximation register loads half scale 200h, then updates each step.
// - One selected channel converts at a time; selection may change between.
// - On finish, done flag bit three sets and result registers load together.
// - Completion raises an interrupt only when control bit four is one.
// - After storing a result the sequencer idles until the next start.
// - An unread result is overwritten by the next conversion.
// - Control bits two and one select the converter clock rate.
// - Each bit takes four converter clocks, plus ten set-up clocks.
// - Speed code 01 makes one converter clock four system clocks.
// - Upper eight result bits in high register, lower two in low register.
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
// Control register keeps its printed index; the bus byte address is four times it
`define SADC_IDX_CTRL     10'h0fa
`define SADC_OFF_CTRL     12'h3e8
`define SADC_OFF_RES_HI   12'h100
`define SADC_OFF_RES_LO   12'h104
`define SADC_OFF_IRQ_STAT 12'h108
`define SADC_OFF_IRQ_MASK 12'h10c
`define SADC_OFF_SAR      12'h110
`define SADC_BIT_START    0
`define SADC_BIT_DONE     3
`define SADC_BIT_IEN      4
`define SADC_CH_LSB       5
`define SADC_SPD_LSB      1
`define SADC_CTRL_RESET   8'h00
`define SADC_SAR_HALF     10'h200
`define SADC_CLK_PER_BIT  4
`define SADC_SETUP_CLKS   10
`define SADC_DIV_SPD0     8
`define SADC_DIV_SPD1     4
`define SADC_DIV_SPD2     2
`define SADC_DIV_SPD3     1
`endif

// file: hw/sadc_pkg.sv
// Types for the converter sequencer
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_IDLE  = 2'b00,
        SADC_SETUP = 2'b01,
        SADC_CONV  = 2'b10,
        SADC_STORE = 2'b11
    } sadc_state_t;
endpackage : sadc_pkg

// file: hw/sadc_sar.sv
// Successive approximation register
`timescale 1ns/100ps
`default_nettype none
`include "sadc_consts.svh"
module sadc_sar #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             load_i,
    input  wire logic             step_i,
    input  wire logic             cmp_i,
    output logic [WIDTH-1:0]      sar_o,
    output logic                  last_o
);
    import sadc_pkg::*;
    logic [WIDTH-1:0] sar_q;
    logic [WIDTH-1:0] trial_q;

    assign sar_o  = sar_q;
    assign last_o = trial_q[0];

    // Half scale load, one bit decided per step
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sar_q   <= '0;
            trial_q <= '0;
        end else if (load_i) begin
            sar_q   <= WIDTH'(`SADC_SAR_HALF);
            trial_q <= WIDTH'(`SADC_SAR_HALF);
        end else if (step_i && trial_q != '0) begin
            sar_q <= (cmp_i ? sar_q : (sar_q & ~trial_q)) | (trial_q >> 1);
            trial_q <= trial_q >> 1;
        end
    end

    a_sar_half: assert property (@(posedge clk_i) disable iff (!nrst_i)
        load_i |=> sar_q == WIDTH'(`SADC_SAR_HALF))
        else $error("approximation register not at half scale after load");
endmodule : sadc_sar
`default_nettype wire

// file: hw/sadc_top.sv
// Converter sequencer with APB register slave
`timescale 1ns/100ps
`default_nettype none
`include "sadc_consts.svh"
module sadc_top (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        cmp_i,
    output logic [2:0]       channel_o,
    output logic             converting_o,
    output logic [9:0]       dac_code_o,
    output logic             irq_o
);
    import sadc_pkg::*;

    sadc_state_t state_q;
    logic [7:0]  ctrl_q;
    logic [9:0]  result_q;
    logic        stat_q;
    logic        mask_q;
    logic [3:0]  phase_q;
    logic        tick;
    logic        wr;
    logic        rd;
    logic        sar_load;
    logic        sar_step;
    logic        sar_last;
    logic        finish;
    logic [9:0]  sar;
    logic [31:0] rdata;
    logic        hit;

    assign wr        = psel_i && penable_i && pwrite_i;
    assign rd        = psel_i && penable_i && !pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;

    assign channel_o    = ctrl_q[`SADC_CH_LSB+2:`SADC_CH_LSB];
    assign converting_o = state_q != SADC_IDLE;
    assign dac_code_o   = sar;
    assign finish       = state_q == SADC_STORE;

    sadc_clkdiv u_div (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .run_i   (converting_o),
        .speed_i (ctrl_q[`SADC_SPD_LSB+1:`SADC_SPD_LSB]),
        .tick_o  (tick)
    );

    sadc_sar #(.WIDTH(10)) u_sar (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .load_i (sar_load),
        .step_i (sar_step),
        .cmp_i  (cmp_i),
        .sar_o  (sar),
        .last_o (sar_last)
    );

    assign sar_load = state_q == SADC_IDLE && ctrl_q[`SADC_BIT_START];
    // Bit decided on fourth converter clock
    assign sar_step = state_q == SADC_CONV && tick
                      && phase_q == 4'(`SADC_CLK_PER_BIT - 1);

    // Set-up then four clocks per bit
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= SADC_IDLE;
            phase_q <= 4'h0;
        end else begin
            case (state_q)
                SADC_IDLE: begin
                    phase_q <= 4'h0;
                    if (sar_load) begin
                        state_q <= SADC_SETUP;
                    end
                end
                SADC_SETUP: begin
                    if (tick) begin
                        if (phase_q == 4'(`SADC_SETUP_CLKS - 1)) begin
                            phase_q <= 4'h0;
                            state_q <= SADC_CONV;
                        end else begin
                            phase_q <= phase_q + 4'h1;
                        end
                    end
                end
                SADC_CONV: begin
                    if (tick) begin
                        phase_q <= (phase_q == 4'(`SADC_CLK_PER_BIT - 1)) ? 4'h0
                                                                          : phase_q + 4'h1;
                        if (sar_step && sar_last) begin
                            state_q <= SADC_STORE;
                        end
                    end
                end
                SADC_STORE: state_q <= SADC_IDLE;
                default:    state_q <= SADC_IDLE;
            endcase
        end
    end

    // Control register: channel, enable, speed, start, done flag
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl_q <= `SADC_CTRL_RESET;
        end else begin
            if (wr && paddr_i == `SADC_OFF_CTRL) begin
                ctrl_q[7:4] <= pwdata_i[7:4];
                ctrl_q[2:0] <= pwdata_i[2:0];
                // Zero write clears the done flag
                if (!pwdata_i[`SADC_BIT_DONE]) begin
                    ctrl_q[`SADC_BIT_DONE] <= 1'b0;
                end
            end
            if (sar_load) begin
                ctrl_q[`SADC_BIT_START] <= 1'b0;
            end
            // Done flag set wins over clear
            if (finish) begin
                ctrl_q[`SADC_BIT_DONE] <= 1'b1;
            end
        end
    end

    // Result stored with flag; unread result overwritten
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            result_q <= 10'h000;
        end else if (finish) begin
            result_q <= sar;
        end
    end

    // Interrupt status and mask
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            stat_q <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            if (wr && paddr_i == `SADC_OFF_IRQ_MASK) begin
                mask_q <= pwdata_i[0];
            end
            if (finish) begin
                stat_q <= 1'b1;
            end else if (wr && paddr_i == `SADC_OFF_IRQ_STAT && pwdata_i[0]) begin
                stat_q <= 1'b0;
            end
        end
    end

    // Request gated by interrupt enable bit
    assign irq_o = stat_q && mask_q && ctrl_q[`SADC_BIT_IEN];

    // Result split high eight and low two
    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr_i)
            `SADC_OFF_CTRL:     rdata[7:0] = ctrl_q;
            `SADC_OFF_RES_HI:   rdata[7:0] = result_q[9:2];
            `SADC_OFF_RES_LO:   rdata[1:0] = result_q[1:0];
            `SADC_OFF_IRQ_STAT: rdata[0]   = stat_q;
            `SADC_OFF_IRQ_MASK: rdata[0]   = mask_q;
            `SADC_OFF_SAR:      rdata[9:0] = sar;
            default:            hit        = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rdata;
        end
    end

    // Channel follows bits seven to five
    a_chan_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
        channel_o == ctrl_q[7:5])
        else $error("channel output differs from control bits");
    a_start_launch: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_q == SADC_IDLE && ctrl_q[0]) |=> state_q == SADC_SETUP)
        else $error("start bit did not launch a conversion");
    a_start_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sar_load && !(wr && paddr_i == `SADC_OFF_CTRL) |=> !ctrl_q[0])
        else $error("start bit not cleared after launch");
    a_done_result: assert property (@(posedge clk_i) disable iff (!nrst_i)
        finish |=> ctrl_q[3] && result_q == $past(sar))
        else $error("done flag or result not updated at finish");
    a_store_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        finish |=> state_q == SADC_IDLE)
        else $error("sequencer not idle after store");
    a_irq_enable: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctrl_q[4] |-> !irq_o)
        else $error("interrupt raised while disabled");
    a_done_keep: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ctrl_q[3] && wr && paddr_i == `SADC_OFF_CTRL && pwdata_i[3]) |=> ctrl_q[3])
        else $error("done flag lost on write of one");
    // Set-up occupies ten converter clocks before bits
    a_setup_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_q == SADC_SETUP && tick && phase_q != 4'd9) |=> state_q == SADC_SETUP)
        else $error("set-up period left early");
    // Channel cannot change during a conversion without a write
    a_chan_steady: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (converting_o && !wr) |=> $stable(channel_o))
        else $error("channel changed without a write");

    c_launch: cover property (@(posedge clk_i) disable iff (!nrst_i) sar_load);
    c_finish: cover property (@(posedge clk_i) disable iff (!nrst_i) finish);
    c_irq:    cover property (@(posedge clk_i) disable iff (!nrst_i) irq_o);
endmodule : sadc_top
`default_nettype wire

// file: tb/sadc_cmp_model.sv
// Behavioural analog channel bank and comparator facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module sadc_cmp_model (
    input  wire logic [2:0] channel_i,
    input  wire logic [9:0] dac_code_i,
    output logic            cmp_o
);
    // Channel levels in code units, with both ends of the scale included
    localparam logic [9:0] LVL [8] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff,
                                       10'h155, 10'h2aa, 10'h001, 10'h3fe};
    assign cmp_o = (LVL[channel_i] >= dac_code_i);
endmodule : sadc_cmp_model
`default_nettype wire

// file: tb/sar_adc_sequencer_tb.sv
// Register level testbench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sadc_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module sar_adc_sequencer_tb;
    localparam logic [9:0] LVL [8] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff,
                                       10'h155, 10'h2aa, 10'h001, 10'h3fe};
    logic        clk_i;
    logic        nrst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        cmp_i;
    logic [2:0]  channel_o;
    logic        converting_o;
    logic [9:0]  dac_code_o;
    logic        irq_o;
    logic [31:0] rd;
    logic        slv;
    int          err_count;
    int          total_checks;

    sadc_top i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .cmp_i(cmp_i), .channel_o(channel_o), .converting_o(converting_o),
        .dac_code_o(dac_code_o), .irq_o(irq_o)
    );
    sadc_cmp_model i_cmp (.channel_i(channel_o), .dac_code_i(dac_code_o), .cmp_o(cmp_i));

    always #20 clk_i = ~clk_i;

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // Setup cycle, then access held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            give_verdict();
        end
        rd  = prdata_o;
        slv = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        // Outputs are looked at mid-cycle, once settled
        @(negedge clk_i);
    endtask : apb

    task automatic conv(input logic [2:0] ch, input logic [1:0] spd, input logic ien);
        logic [7:0] ctl;
        int         n;
        int         dv;
        ctl = {ch, ien, 1'b0, spd, 1'b0};
        dv  = 8 >> spd;
        apb(1'b1, `SADC_OFF_IRQ_STAT, 32'h1);
        apb(1'b1, `SADC_OFF_CTRL, {24'h0, ctl});
        apb(1'b1, `SADC_OFF_CTRL, {24'h0, ctl | 8'h01});
        @(negedge clk_i);
        @(negedge clk_i);
        `CHK(converting_o, 1'b1)
        `CHK(dac_code_o, 10'h200)
        `CHK(channel_o, ch)
        apb(1'b0, `SADC_OFF_CTRL, 32'h0);
        `CHK(rd[0], 1'b0)
        n = 4;
        while (converting_o === 1'b1 && n < 1000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 1000) begin
            err_count++;
            give_verdict();
        end
        `CHK(n >= 50 * dv && n <= 50 * dv + 8, 1'b1)
        apb(1'b0, `SADC_OFF_CTRL, 32'h0);
        `CHK(rd[3], 1'b1)
        `CHK(converting_o, 1'b0)
        apb(1'b0, `SADC_OFF_RES_HI, 32'h0);
        `CHK(rd[7:0], LVL[ch][9:2])
        apb(1'b0, `SADC_OFF_RES_LO, 32'h0);
        `CHK(rd[1:0], LVL[ch][1:0])
        apb(1'b0, `SADC_OFF_SAR, 32'h0);
        `CHK(rd[9:0], LVL[ch])
        `CHK(irq_o, ien)
        apb(1'b1, `SADC_OFF_CTRL, {24'h0, ctl | 8'h08});
        apb(1'b0, `SADC_OFF_CTRL, 32'h0);
        `CHK(rd[3], 1'b1)
        apb(1'b1, `SADC_OFF_CTRL, {24'h0, ctl});
        apb(1'b0, `SADC_OFF_CTRL, 32'h0);
        `CHK(rd[3], 1'b0)
        `CHK(converting_o, 1'b0)
        apb(1'b1, `SADC_OFF_IRQ_STAT, 32'h1);
        apb(1'b0, `SADC_OFF_IRQ_STAT, 32'h0);
        `CHK(rd[0], 1'b0)
        `CHK(irq_o, 1'b0)
        $display("test channel %0d done", ch);
    endtask : conv

    initial begin
        clk_i        = 1'b0;
        nrst_i       = 1'b0;
        psel_i       = 1'b0;
        penable_i    = 1'b0;
        pwrite_i     = 1'b0;
        paddr_i      = 12'h000;
        pwdata_i     = 32'h0;
        err_count    = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, `SADC_OFF_CTRL, 32'h0);
        `CHK(rd[7:0], `SADC_CTRL_RESET)
        `CHK(converting_o, 1'b0)
        `CHK(irq_o, 1'b0)
        apb(1'b0, 12'h0f0, 32'h0);
        `CHK(slv, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, `SADC_OFF_IRQ_MASK, 32'h1);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            conv(c[2:0], c[1:0], c[0]);
        end
        give_verdict();
    end
endmodule : sar_adc_sequencer_tb
`default_nettype wire
